// ---- inc/dmad_defs.vh ----
// Constants for the debug memory access data path
// Summary of operation
// [R1] A memory bus error ends the access and returns an error to the debug port.
// [R2] With sub-word support, byte, halfword and word sizes are all provided.
// [R3] Size code 000 is byte, 001 halfword, 010 word; 110 and 111 reserved.
// [R4] Codes 011 to 101 are reserved here, since no large data option exists.
// [R5] A word-only build keeps the size field fixed, reading back the word code.
// [R6] The debugger uses banked windows only with word size selected.
// [R7] Byte accesses use the lane chosen by the low two address bits.
// [R8] Halfwords use bits 15:0 or 31:16; an aligned word uses all 32 bits.
// [R9] Misaligned halfword or word accesses are faulted with an error.
// [R10] Lanes are little-endian: lowest address is the least significant byte.
// [R11] A debugger facing big-endian memory reorders bytes itself; no swapping here.
// [R12] Packed transfers are enabled by writing the packed code to the increment field.
// [R13] Packed: one word access, two halfword accesses or four byte accesses.
// [R14] The debugger never enables packing with sizes above word.
// [R15] Pushed compares run only once the full packed word is assembled.
// [R16] In packed mode the address advances by each successful access size.
// [R17] Sub-accesses go in ascending address order, each in its own byte lane.
// [R18] An error on any sub-access halts the sequence and reports the error.
// [R19] A packed read completes only after the whole word is filled.
// [R20] Each repeated counter transaction moves one word, split when packing.
// [R21] Auto-increment carries only within the low 10 address bits.
// [R22] Without packing support the packed code selects no increment, reading 00.
// [R23] Window accesses stall as long as the memory bus access takes.
`ifndef DMAD_DEFS_VH
`define DMAD_DEFS_VH

// Register byte offsets
`define DMAD_OFS_CSW 4'h0
`define DMAD_OFS_TAR 4'h4
`define DMAD_OFS_DRW 4'h8

// Control status word fields
`define DMAD_SIZE_LSB 0
`define DMAD_INC_LSB 4
`define DMAD_ERR_BIT 8
`define DMAD_CMP_BIT 9
`define DMAD_BUSY_BIT 10

// Size codes
`define DMAD_SZ_BYTE 3'h0
`define DMAD_SZ_HALF 3'h1
`define DMAD_SZ_WORD 3'h2

// Increment modes
`define DMAD_INC_OFF 2'h0
`define DMAD_INC_SINGLE 2'h1
`define DMAD_INC_PACKED 2'h2

// Pushed compare modes
`define DMAD_CMP_NONE 2'h0
`define DMAD_CMP_EQUAL 2'h1
`define DMAD_CMP_VERIFY 2'h2

// Reset values
`define DMAD_RST_SIZE 3'h2
`define DMAD_RST_INC 2'h0
`define DMAD_RST_TAR 32'h0000_0000

// Guaranteed auto-increment width
`define DMAD_INC_BITS 10

`endif

// ---- core/dmad_lane.v ----
// Byte lane, alignment and step decode for one memory access
`timescale 1ns/10ps
`include "dmad_defs.vh"

module dmad_lane (
   // Access shape
   input wire [2:0] size_i,
   input wire [1:0] lo_i,
   // Decode
   output reg [3:0] be_o,
   output reg mis_o,
   output reg bad_size_o,
   output reg [2:0] step_o
);

   always @* begin
      be_o = 4'h0;
      mis_o = 1'b0;
      bad_size_o = 1'b0;
      step_o = 3'h4;
      case (size_i)
         // [R7] Byte lane select
         `DMAD_SZ_BYTE: begin
            be_o = 4'h1 << lo_i;
            step_o = 3'h1;
         end
         // [R8] Halfword lane select
         `DMAD_SZ_HALF: begin
            be_o = lo_i[1] ? 4'hc : 4'h3;
            // [R9] Odd halfword faults
            mis_o = lo_i[0];
            step_o = 3'h2;
         end
         `DMAD_SZ_WORD: begin
            be_o = 4'hf;
            // [R9] Unaligned word faults
            mis_o = (lo_i != 2'h0);
            step_o = 3'h4;
         end
         // [R3] [R4] Reserved sizes fault
         default: begin
            bad_size_o = 1'b1;
         end
      endcase
   end

endmodule // dmad_lane

// ---- core/dmad_core.v ----
// Debug memory access data path with a Wishbone register slave
`timescale 1ns/10ps
`include "dmad_defs.vh"

module dmad_core #(
   parameter SUB_WORD = 1,
   parameter PACKED = 1,
   parameter INC_BITS = `DMAD_INC_BITS
) (
   // Clock and reset
   input wire clk_i,
   input wire resetn_i,
   // Wishbone register slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire wb_ack_o,
   // Debug port front end window access
   input wire dp_req_i,
   input wire dp_we_i,
   input wire dp_bank_i,
   input wire [1:0] dp_bank_sel_i,
   input wire [1:0] dp_cmp_mode_i,
   input wire [31:0] dp_wdata_i,
   output wire dp_ready_o,
   output wire dp_done_o,
   output wire dp_err_o,
   output wire [31:0] dp_rdata_o,
   // Memory bus master
   output wire mem_req_o,
   output wire mem_we_o,
   output wire [31:0] mem_addr_o,
   output wire [2:0] mem_size_o,
   output wire [3:0] mem_be_o,
   output wire [31:0] mem_wdata_o,
   input wire mem_ack_i,
   input wire mem_err_i,
   input wire [31:0] mem_rdata_i,
   // Status
   output wire sticky_error_flag_o,
   output wire sticky_compare_flag_o
);

   localparam S_IDLE = 2'h0;
   localparam S_ISSUE = 2'h1;
   localparam S_WAIT = 2'h2;

   // Byte-wise merge under an enable mask
   function [31:0] lane_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0] en;
      integer i;
      begin
         lane_merge = old_v;
         for (i = 0; i < 4; i = i + 1) begin
            if (en[i]) begin
               lane_merge[8*i +: 8] = new_v[8*i +: 8];
            end
         end
      end
   endfunction

   // Address increment confined to the low bits
   function [31:0] addr_incr;
      input [31:0] a;
      input [2:0] step;
      reg [31:0] mask;
      reg [31:0] sum;
      begin
         mask = (32'h1 << INC_BITS) - 32'h1;
         sum = a + {29'h0, step};
         addr_incr = (a & ~mask) | (sum & mask);
      end
   endfunction

   reg [1:0] state_r;
   reg [2:0] size_r;
   reg [1:0] inc_r;
   reg [31:0] tar_r;
   reg [31:0] data_r;
   reg [31:0] cmpv_r;
   reg err_flag_r;
   reg cmp_flag_r;
   reg [2:0] left_r;
   reg we_r;
   reg bank_r;
   reg [1:0] bsel_r;
   reg [1:0] cmode_r;
   reg mem_req_r;
   reg [31:0] mem_addr_r;
   reg [2:0] mem_size_r;
   reg [3:0] mem_be_r;
   reg [2:0] step_r;
   reg done_r;
   reg derr_r;
   reg wb_ack_r;
   reg [31:0] wb_dat_r;

   wire [2:0] eff_size;
   wire packed_on;
   wire [31:0] acc_addr;
   wire [3:0] lane_be;
   wire lane_mis;
   wire lane_bad;
   wire [2:0] lane_step;
   wire wb_hit;
   wire wb_wr;
   wire csw_wr;
   wire tar_wr;
   wire [31:0] csw_rd;
   wire [31:0] csw_new;
   wire [31:0] rd_word;
   wire set_err;
   wire set_cmp;
   wire clr_err;
   wire clr_cmp;
   wire last_ok;
   wire [1:0] inc_new;

   // [R5] Word-only build fixes the size
   assign eff_size = (SUB_WORD != 0) ? size_r : `DMAD_SZ_WORD;
   // [R12] Packed code enables packing
   assign packed_on = (PACKED != 0) && (SUB_WORD != 0) && (inc_r == `DMAD_INC_PACKED);
   assign acc_addr = bank_r ? {tar_r[31:4], bsel_r, 2'h0} : tar_r;

   dmad_lane u_lane (
      .size_i(eff_size),
      .lo_i(acc_addr[1:0]),
      .be_o(lane_be),
      .mis_o(lane_mis),
      .bad_size_o(lane_bad),
      .step_o(lane_step)
   );

   // Wishbone decode
   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_r;
   assign wb_wr = wb_hit && wb_we_i;
   assign csw_wr = wb_wr && (wb_adr_i == `DMAD_OFS_CSW);
   assign tar_wr = wb_wr && (wb_adr_i == `DMAD_OFS_TAR);
   assign csw_new = lane_merge(csw_rd, wb_dat_i, wb_sel_i);
   assign clr_err = csw_wr && wb_sel_i[1] && wb_dat_i[`DMAD_ERR_BIT];
   assign clr_cmp = csw_wr && wb_sel_i[1] && wb_dat_i[`DMAD_CMP_BIT];
   assign csw_rd = {21'h0, (state_r != S_IDLE), cmp_flag_r, err_flag_r, 2'h0, inc_r, 1'b0, eff_size};

   // [R22] Packed code falls back to no increment
   assign inc_new = (csw_new[`DMAD_INC_LSB +: 2] == `DMAD_INC_PACKED && (PACKED == 0 || SUB_WORD == 0))
                    ? `DMAD_INC_OFF : csw_new[`DMAD_INC_LSB +: 2];

   // [R10] [R17] Read data lands in its own lane
   assign rd_word = lane_merge(data_r, mem_rdata_i, mem_be_r);
   assign last_ok = (state_r == S_WAIT) && !mem_err_i && mem_ack_i && (left_r == 3'h1);

   // [R1] [R18] Errors from faults or the bus
   assign set_err = ((state_r == S_ISSUE) && (lane_mis || lane_bad)) || ((state_r == S_WAIT) && mem_err_i);

   // [R15] Compare only on the full word
   assign set_cmp = last_ok && !we_r &&
                    (((cmode_r == `DMAD_CMP_EQUAL) && (rd_word == cmpv_r)) ||
                     ((cmode_r == `DMAD_CMP_VERIFY) && (rd_word != cmpv_r)));

   // Transfer state machine
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         state_r <= S_IDLE;
         tar_r <= `DMAD_RST_TAR;
         data_r <= 32'h0;
         cmpv_r <= 32'h0;
         left_r <= 3'h0;
         we_r <= 1'b0;
         bank_r <= 1'b0;
         bsel_r <= 2'h0;
         cmode_r <= `DMAD_CMP_NONE;
         mem_req_r <= 1'b0;
         mem_addr_r <= 32'h0;
         mem_size_r <= `DMAD_SZ_WORD;
         mem_be_r <= 4'h0;
         step_r <= 3'h0;
         done_r <= 1'b0;
         derr_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         derr_r <= 1'b0;
         case (state_r)
            S_IDLE: begin
               if (dp_req_i) begin
                  we_r <= dp_we_i;
                  bank_r <= dp_bank_i;
                  bsel_r <= dp_bank_sel_i;
                  cmode_r <= dp_cmp_mode_i;
                  cmpv_r <= dp_wdata_i;
                  if (dp_we_i) begin
                     data_r <= dp_wdata_i;
                  end
                  // [R13] [R20] Sub-access count per word
                  if (packed_on && !dp_bank_i && eff_size == `DMAD_SZ_BYTE) begin
                     left_r <= 3'h4;
                  end else if (packed_on && !dp_bank_i && eff_size == `DMAD_SZ_HALF) begin
                     left_r <= 3'h2;
                  end else begin
                     left_r <= 3'h1;
                  end
                  state_r <= S_ISSUE;
               end
            end
            S_ISSUE: begin
               if (lane_mis || lane_bad) begin
                  done_r <= 1'b1;
                  derr_r <= 1'b1;
                  state_r <= S_IDLE;
               end else begin
                  mem_req_r <= 1'b1;
                  mem_addr_r <= acc_addr;
                  mem_size_r <= eff_size;
                  mem_be_r <= lane_be;
                  step_r <= lane_step;
                  state_r <= S_WAIT;
               end
            end
            // [R23] Hold until the bus answers
            S_WAIT: begin
               if (mem_err_i) begin
                  // [R18] Halt the sequence
                  mem_req_r <= 1'b0;
                  done_r <= 1'b1;
                  derr_r <= 1'b1;
                  state_r <= S_IDLE;
               end else if (mem_ack_i) begin
                  mem_req_r <= 1'b0;
                  if (!we_r) begin
                     data_r <= rd_word;
                  end
                  // [R16] [R21] Advance after success
                  if (!bank_r && (inc_r == `DMAD_INC_SINGLE || packed_on)) begin
                     tar_r <= addr_incr(tar_r, step_r);
                  end
                  left_r <= left_r - 3'h1;
                  // [R19] Finish only on the last piece
                  if (left_r == 3'h1) begin
                     done_r <= 1'b1;
                     state_r <= S_IDLE;
                  end else begin
                     state_r <= S_ISSUE;
                  end
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
         if (tar_wr) begin
            tar_r <= lane_merge(tar_r, wb_dat_i, wb_sel_i);
         end
      end
   end

   // Control fields and sticky flags
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         size_r <= `DMAD_RST_SIZE;
         inc_r <= `DMAD_RST_INC;
         err_flag_r <= 1'b0;
         cmp_flag_r <= 1'b0;
      end else begin
         if (csw_wr) begin
            // [R2] [R5] Size writable only with sub-word support
            if (SUB_WORD != 0) begin
               size_r <= csw_new[`DMAD_SIZE_LSB +: 3];
            end
            inc_r <= inc_new;
         end
         err_flag_r <= set_err | (err_flag_r & ~clr_err);
         cmp_flag_r <= set_cmp | (cmp_flag_r & ~clr_cmp);
      end
   end

   // Wishbone answer
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         wb_ack_r <= 1'b0;
         wb_dat_r <= 32'h0;
      end else begin
         wb_ack_r <= wb_hit;
         if (wb_hit && !wb_we_i) begin
            case (wb_adr_i)
               `DMAD_OFS_CSW: wb_dat_r <= csw_rd;
               `DMAD_OFS_TAR: wb_dat_r <= tar_r;
               `DMAD_OFS_DRW: wb_dat_r <= data_r;
               default: wb_dat_r <= 32'h0;
            endcase
         end
      end
   end

   assign wb_ack_o = wb_ack_r;
   assign wb_dat_o = wb_dat_r;
   assign dp_ready_o = (state_r == S_IDLE);
   assign dp_done_o = done_r;
   assign dp_err_o = derr_r;
   // [R10] Little-endian window, no swapping
   assign dp_rdata_o = data_r;
   assign mem_req_o = mem_req_r;
   assign mem_we_o = we_r;
   assign mem_addr_o = mem_addr_r;
   assign mem_size_o = mem_size_r;
   assign mem_be_o = mem_be_r;
   assign mem_wdata_o = data_r;
   assign sticky_error_flag_o = err_flag_r;
   assign sticky_compare_flag_o = cmp_flag_r;

endmodule // dmad_core

// ---- bench/dmad_mem_model.sv ----
// Memory bus partner with settable latency and one faulting address
`timescale 1ns/10ps
module dmad_mem_model (
   // Clock and reset
   input wire clk_i,
   input wire resetn_i,
   // Bus from the data path
   input wire req_i,
   input wire we_i,
   input wire [31:0] addr_i,
   input wire [3:0] be_i,
   input wire [31:0] wdata_i,
   // Behaviour
   input wire [3:0] lat_i,
   input wire [31:0] err_addr_i,
   // Answer
   output reg ack_o,
   output reg err_o,
   output reg [31:0] rdata_o
);
   reg [7:0] mem [0:63];
   reg [3:0] cnt_r;
   integer k;
   initial begin
      for (k = 0; k < 64; k = k + 1)
         mem[k] = 8'h00;
      rdata_o = 32'h5a5a_5a5a;
   end
   always @(posedge clk_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= ~rdata_o;
      cnt_r <= 4'h0;
      if (resetn_i && req_i && !ack_o && !err_o && cnt_r < lat_i)
         cnt_r <= cnt_r + 4'h1;
      else if (resetn_i && req_i && !ack_o && !err_o) begin
         err_o <= (addr_i == err_addr_i);
         ack_o <= (addr_i != err_addr_i);
         // Lanes kept as addressed, no swapping
         for (k = 0; k < 4; k = k + 1) begin
            rdata_o[8*k +: 8] <= mem[{addr_i[5:2], k[1:0]}];
            if (we_i && be_i[k] && addr_i != err_addr_i)
               mem[{addr_i[5:2], k[1:0]}] <= wdata_i[8*k +: 8];
         end
      end
   end
endmodule // dmad_mem_model

// ---- bench/dmad_core_chk.sv ----
// Concurrent checks on the data path ports
`timescale 1ns/10ps
module dmad_core_chk #(
   parameter SUB_WORD = 1,
   parameter PACKED = 1,
   parameter INC_BITS = 10
) (
   // Clock and reset
   input wire clk_i,
   input wire resetn_i,
   // Window side
   input wire dp_done_o,
   input wire dp_err_o,
   // Memory side
   input wire mem_req_o,
   input wire [31:0] mem_addr_o,
   input wire [2:0] mem_size_o,
   input wire [3:0] mem_be_o,
   input wire [31:0] mem_wdata_o,
   input wire mem_ack_i,
   input wire mem_err_i,
   // Status
   input wire sticky_error_flag_o,
   input wire sticky_compare_flag_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);
   sequence s_idle2;
      !mem_req_o [*2];
   endsequence
   sequence s_held;
      mem_req_o && $stable(mem_addr_o) && $stable(mem_be_o) && $stable(mem_wdata_o);
   endsequence
   a_err_with_done: assert property (dp_err_o |-> dp_done_o)
      else $error("error pulse without done");
   a_err_sets_sticky: assert property (dp_err_o |=> sticky_error_flag_o)
      else $error("sticky error not set");
   a_byte_lane: assert property (mem_req_o && mem_size_o == 3'h0 |->
      mem_be_o == 4'h1 << mem_addr_o[1:0])
      else $error("byte lane wrong");
   a_half_lane: assert property (mem_req_o && mem_size_o == 3'h1 |->
      !mem_addr_o[0] && mem_be_o == (mem_addr_o[1] ? 4'hc : 4'h3))
      else $error("halfword lane wrong");
   a_word_lane: assert property (mem_req_o && mem_size_o == 3'h2 |->
      mem_be_o == 4'hf && mem_addr_o[1:0] == 2'h0)
      else $error("word lane wrong");
   a_size_legal: assert property (mem_req_o |-> mem_size_o <= 3'h2)
      else $error("reserved size on bus");
   a_req_held: assert property (mem_req_o && !mem_ack_i && !mem_err_i |=> s_held)
      else $error("request dropped while stalled");
   a_halt_on_err: assert property (mem_req_o && mem_err_i |=> s_idle2)
      else $error("access after error");
   a_cmp_at_end: assert property ($rose(sticky_compare_flag_o) |-> dp_done_o || $past(dp_done_o))
      else $error("compare flag before word done");
endmodule // dmad_core_chk
bind dmad_core dmad_core_chk #(.SUB_WORD(SUB_WORD), .PACKED(PACKED), .INC_BITS(INC_BITS)) u_chk (
   .clk_i(clk_i), .resetn_i(resetn_i), .dp_done_o(dp_done_o), .dp_err_o(dp_err_o),
   .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_size_o(mem_size_o), .mem_be_o(mem_be_o),
   .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .mem_err_i(mem_err_i),
   .sticky_error_flag_o(sticky_error_flag_o), .sticky_compare_flag_o(sticky_compare_flag_o));

// ---- bench/dmad_core_tb.sv ----
// Testbench for the debug memory access data path
`timescale 1ns/10ps
module dmad_core_tb;
   logic clk_i = 0, resetn_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic dp_req_i = 0, dp_we_i = 0, dp_bank_i = 0, e;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf, lat = 4'h0;
   logic [1:0] dp_bank_sel_i = 2'h0, dp_cmp_mode_i = 2'h0;
   logic [31:0] wb_dat_i = 32'h0, dp_wdata_i = 32'h0, err_adr = 32'hffff_ffff, q, q2;
   wire [31:0] wb_dat_o, dp_rdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i, wb_dat_w;
   wire [3:0] mem_be_o;
   wire [2:0] mem_size_o;
   wire wb_ack_o, dp_ready_o, dp_done_o, dp_err_o, mem_req_o, mem_we_o, mem_ack_i, mem_err_i, sef, scf;
   integer n_errors = 0, n_tests = 0, n_acc = 0, n_cyc = 0, a0;
   dmad_core u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .dp_req_i(dp_req_i), .dp_we_i(dp_we_i), .dp_bank_i(dp_bank_i),
      .dp_bank_sel_i(dp_bank_sel_i), .dp_cmp_mode_i(dp_cmp_mode_i), .dp_wdata_i(dp_wdata_i),
      .dp_ready_o(dp_ready_o), .dp_done_o(dp_done_o), .dp_err_o(dp_err_o), .dp_rdata_o(dp_rdata_o),
      .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_size_o(mem_size_o),
      .mem_be_o(mem_be_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .mem_err_i(mem_err_i),
      .mem_rdata_i(mem_rdata_i), .sticky_error_flag_o(sef), .sticky_compare_flag_o(scf));
   // Word-only copy on the same register bus
   dmad_core #(.SUB_WORD(0), .PACKED(0)) u_word (.clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_w), .wb_ack_o(), .dp_req_i(1'b0), .dp_we_i(1'b0), .dp_bank_i(1'b0), .dp_bank_sel_i(2'h0),
      .dp_cmp_mode_i(2'h0), .dp_wdata_i(32'h0), .dp_ready_o(), .dp_done_o(), .dp_err_o(), .dp_rdata_o(),
      .mem_req_o(), .mem_we_o(), .mem_addr_o(), .mem_size_o(), .mem_be_o(), .mem_wdata_o(), .mem_ack_i(1'b0),
      .mem_err_i(1'b0), .mem_rdata_i(32'h0), .sticky_error_flag_o(), .sticky_compare_flag_o());
   dmad_mem_model u_mem (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(mem_req_o), .we_i(mem_we_o),
      .addr_i(mem_addr_o), .be_i(mem_be_o), .wdata_i(mem_wdata_o), .lat_i(lat), .err_addr_i(err_adr),
      .ack_o(mem_ack_i), .err_o(mem_err_i), .rdata_o(mem_rdata_i));
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   task print_verdict;
      begin
         $display("errors %0d tests %0d", n_errors, n_tests);
         if (n_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   always @(posedge clk_i) begin
      n_cyc <= n_cyc + 1;
      if (mem_req_o && (mem_ack_i || mem_err_i))
         n_acc <= n_acc + 1;
      if (n_cyc == 20000) begin
         n_errors = n_errors + 1;
         print_verdict;
      end
   end
   task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      begin
         wb_cyc_i <= 1;
         wb_stb_i <= 1;
         wb_we_i <= we;
         wb_adr_i <= a;
         wb_dat_i <= d;
         do
            @(posedge clk_i);
         while (wb_ack_o !== 1'b1);
         q = wb_dat_o;
         q2 = wb_dat_w;
         wb_cyc_i <= 0;
         wb_stb_i <= 0;
         @(posedge clk_i);
      end
   endtask
   task dp_op(input logic we, input logic [1:0] cm, input logic [31:0] wd);
      integer t;
      begin
         @(posedge clk_i);
         a0 = n_acc;
         dp_req_i <= 1;
         dp_we_i <= we;
         dp_cmp_mode_i <= cm;
         dp_wdata_i <= wd;
         do
            @(posedge clk_i);
         while (dp_ready_o !== 1'b1);
         dp_req_i <= 0;
         t = 0;
         do begin
            @(posedge clk_i);
            t = t + 1;
            if (t == 1)
               chk("busy", dp_ready_o, 0);
         end while (dp_done_o !== 1'b1 && t < 100);
         chk("done", dp_done_o, 1);
         q = dp_rdata_o;
         e = dp_err_o;
      end
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      resetn_i <= 1;
      @(posedge clk_i);
      wb(0, 4'h0, 0);
      chk("csw rst", q, 32'h2);
      wb(0, 4'h4, 0);
      chk("tar rst", q, 0);
      wb(0, 4'hc, 0);
      chk("unmapped", q, 0);
      // Word-only copy keeps its size and turns packed into off
      wb(1, 4'h0, 32'h11);
      wb(0, 4'h0, 0);
      chk("csw single", q, 32'h11);
      chk("word size", q2, 32'h12);
      wb(1, 4'h0, 32'h20);
      wb(0, 4'h0, 0);
      chk("csw packed", q, 32'h20);
      chk("word packed", q2, 32'h2);
      wb(1, 4'h4, 32'h2);
      dp_op(1, 0, 32'h4433_2211);
      chk("acc byte", n_acc - a0, 4);
      chk("mem2", u_mem.mem[2], 8'h33);
      chk("mem5", u_mem.mem[5], 8'h22);
      wb(0, 4'h4, 0);
      chk("tar byte", q, 6);
      // Only the low read lanes differ from what the window held before
      lat <= 4'h3;
      wb(1, 4'h0, 32'h21);
      wb(1, 4'h4, 32'h0);
      dp_op(0, 2'h1, 32'h4433_0000);
      chk("rd half", q, 32'h4433_0000);
      chk("acc half", n_acc - a0, 2);
      chk("scf", scf, 1);
      wb(0, 4'h0, 0);
      chk("cmp flag", q[9], 1);
      lat <= 4'h0;
      wb(1, 4'h0, 32'h212);
      wb(1, 4'h4, 32'h7fc);
      dp_op(1, 0, 32'hcafe_0123);
      chk("acc word", n_acc - a0, 1);
      chk("mem60", u_mem.mem[60], 8'h23);
      wb(0, 4'h4, 0);
      chk("tar wrap", q, 32'h400);
      wb(1, 4'h0, 32'h1);
      wb(1, 4'h4, 32'h1);
      dp_op(0, 0, 0);
      chk("mis err", e, 1);
      chk("mis acc", n_acc - a0, 0);
      chk("sef", sef, 1);
      wb(0, 4'h0, 0);
      chk("sticky", q[8], 1);
      wb(1, 4'h0, 32'h301);
      wb(0, 4'h0, 0);
      chk("w1c", q[9:8], 0);
      // Banked word write: fixed slot address, no increment
      wb(1, 4'h0, 32'h12);
      wb(1, 4'h4, 32'h20);
      dp_bank_i <= 1;
      dp_bank_sel_i <= 2'h2;
      dp_op(1, 0, 32'h5566_7788);
      dp_bank_i <= 0;
      chk("bank mem", u_mem.mem[41], 8'h77);
      chk("bank acc", n_acc - a0, 1);
      wb(0, 4'h4, 0);
      chk("bank tar", q, 32'h20);
      wb(1, 4'h4, 0);
      for (int c = 3; c < 8; c++) begin
         wb(1, 4'h0, c);
         dp_op(0, 0, 0);
         chk("rsv err", e, 1);
         chk("rsv acc", n_acc - a0, 0);
      end
      err_adr <= 32'h11;
      wb(1, 4'h0, 32'h20);
      wb(1, 4'h4, 32'h10);
      dp_op(1, 0, 0);
      chk("halt err", e, 1);
      chk("halt acc", n_acc - a0, 2);
      wb(0, 4'h4, 0);
      chk("halt tar", q, 32'h11);
      print_verdict;
   end
endmodule // dmad_core_tb
